// ### mct_pkg.sv
package mct_pkg;

  // Channel count and data widths
  localparam int NCH = 6;
  localparam int NREG = 16;
  localparam int NFLG = 6;

  // Register offsets on the plain register port
  localparam logic [7:0] ADR_FLAG_BASE = 8'h00; // status flags, + channel
  localparam logic [7:0] ADR_CNT_BASE = 8'h08;  // counters, + channel
  localparam logic [7:0] ADR_GREG_BASE = 8'h10; // general regs, + index
  localparam logic [7:0] ADR_RUN = 8'h20;       // counter_run_control
  localparam logic [7:0] ADR_SYNC = 8'h21;      // counter_sync_select
  localparam logic [7:0] ADR_HALT = 8'h22;      // module_halt_control
  localparam logic [7:0] ADR_IOC_BASE = 8'h28;  // io_control_reg, + channel
  localparam logic [7:0] ADR_MODE_BASE = 8'h30; // mode_reg, + channel

  // Reset values
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] GREG_RST = 16'hffff;
  localparam logic [7:0] RUN_RST = 8'h00;
  localparam logic [7:0] SYNC_RST = 8'h00;
  localparam logic [15:0] HALT_RST = 16'h3fff;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [15:0] ONE16 = 16'h0001;

  // Writable bits of run and sync registers (bits 7 and 6 reserved)
  localparam logic [7:0] CHAN_MASK = 8'h3f;
  localparam int HALT_BIT = 13; // timer_halt_bit

  // Status flag positions
  localparam int FLG_A = 0;
  localparam int FLG_B = 1;
  localparam int FLG_C = 2;
  localparam int FLG_D = 3;
  localparam int FLG_V = 4;
  localparam int FLG_U = 5;

  // io_control_reg fields
  localparam int IOC_CAP_LSB = 0; // one capture-mode bit per reg A..D
  localparam int IOC_INIT = 4;    // initial output level
  localparam int IOC_OE = 5;      // pin driven as compare output

  // mode_reg fields
  localparam int MODE_CCLR_LSB = 0; // clear_source_select, 3 bits
  localparam int MODE_UPDN = 3;     // phase or cascade counting allowed
  localparam int MODE_DOWN = 4;     // count direction down
  localparam int MODE_BUFA = 5;     // reg C buffers reg A
  localparam int MODE_BUFB = 6;     // reg D buffers reg B

  // clear_source_select codes
  localparam logic [2:0] CCLR_NONE = 3'h0;
  localparam logic [2:0] CCLR_A = 3'h1;
  localparam logic [2:0] CCLR_B = 3'h2;
  localparam logic [2:0] CCLR_SYNC = 3'h3;
  localparam logic [2:0] CCLR_C = 3'h5;
  localparam logic [2:0] CCLR_D = 3'h6;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } mct_bus_req_t;

  // Transfer controller activation, per channel and reg A..D
  typedef struct packed {
    logic [NCH-1:0][3:0] act;
    logic [NCH-1:0][3:0] disable_after_transfer_bit;
  } mct_xfer_t;

endpackage

// ### mct_timer.sv
// Operation
// - Compare match sets flag A, B, C or D
// - Input capture copies counter, sets flag
// - Zero write after reading one clears flag
// - Transfer activation clears flag unless disabled
// - Six 16-bit counters; 0 and 3 up
// - Counters reset to zero, also standby
// - Others count down only in phase mode
// - Sixteen general registers, 4/2 per channel
// - Channels 0,3: C buffers A, D B
// - General registers reset to all ones
// - Run bits 5..0 start and stop counters
// - Run register resets zero; reserved bits zero
// - Stopping keeps compare output pin level
// - I/O write while stopped sets initial level
// - Sync bits select synchronous preset and clear
// - Sync register resets zero; reserved bits zero
// - Halt bit stops timer, blocks register access
// - Halt register resets 0x3fff, timer halted
// - Synchronised counter write presets all synchronised counters
// - Flags take only zero writes to clear
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ns
module mct_timer (
  input wire logic clk_sys, // System clock, 10 MHz
  input wire logic rst_b, // Asynchronous reset, active low
  input wire logic hw_standby, // Hardware standby, initialises state
  input wire mct_pkg::mct_bus_req_t bus, // Register port request
  output logic [15:0] rd_data, // Read data, cycle after read strobe
  input wire logic [5:0] count_tick, // Count clock enable per channel
  input wire logic [5:0][3:0] capture_evt, // Capture strobes, regs A..D
  input wire mct_pkg::mct_xfer_t xfer, // Transfer controller activation
  output logic [5:0] pin_out, // Compare output level per channel
  output logic [5:0] pin_oe // Compare output drive enable
);
  import mct_pkg::*;

  // Register state
  logic [15:0] halt_ctrl; // module_halt_control
  logic [7:0] run_ctrl; // counter_run_control
  logic [7:0] sync_sel; // counter_sync_select
  logic [NCH-1:0][7:0] ioc; // io_control_reg per channel
  logic [NCH-1:0][7:0] mode; // mode_reg per channel
  logic [NCH-1:0][15:0] cnt; // channel_counter
  logic [NREG-1:0][15:0] greg; // compare_capture_general
  logic [NCH-1:0][NFLG-1:0] flag; // channel_status_flags
  logic [NCH-1:0][NFLG-1:0] armed; // Flag was read as one

  // Decoded strobes and events
  logic halted; // Timer in module stop
  logic acc_ok; // Register access permitted
  logic [NCH-1:0] run; // Counter advances this cycle
  logic [NCH-1:0] down; // Counter counts downward
  logic [NCH-1:0][3:0] match; // Compare match per reg
  logic [NCH-1:0][3:0] cap; // Input capture per reg
  logic [NCH-1:0] ovf; // Overflow event
  logic [NCH-1:0] unf; // Underflow event
  logic [NCH-1:0] own_clr; // Channel's own clear source fired
  logic [NCH-1:0] clr; // Counter clears this cycle
  logic [NCH-1:0] cnt_wr; // Software writes this counter
  logic [NCH-1:0] flag_wr; // Software writes this flag register
  logic [NCH-1:0] flag_rd; // Software reads this flag register
  logic [NCH-1:0] ioc_wr; // Software writes this io_control_reg
  logic [NCH-1:0] mode_wr; // Software writes this mode_reg
  logic [NREG-1:0] greg_wr; // Software writes this general reg
  logic sync_preset; // A synchronised counter was written
  logic sync_clr; // A synchronised channel cleared itself

  // Index of general register r of channel ch
  function automatic logic [3:0] greg_idx(input int ch, input int r);
    logic [3:0] base;
    base = 4'h0;
    unique case (ch)
      0: base = 4'h0;
      1: base = 4'h4;
      2: base = 4'h6;
      3: base = 4'h8;
      4: base = 4'hc;
      default: base = 4'he;
    endcase
    return base + 4'(r);
  endfunction

  // Channels with four general registers and up-only counters
  function automatic logic has_cd(input int ch);
    return (ch == 0) || (ch == 3);
  endfunction

  // Register r exists on channel ch
  function automatic logic reg_ok(input int ch, input int r);
    return (r < 2) || has_cd(ch);
  endfunction

  // Address equals base plus offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] base,
                               input int n);
    return a == (base + 8'(n));
  endfunction

  // Does the selected clear source fire
  function automatic logic clr_hit(input logic [2:0] sel,
                                   input logic [3:0] ev);
    logic h;
    h = 1'b0;
    unique case (sel)
      CCLR_A: h = ev[FLG_A];
      CCLR_B: h = ev[FLG_B];
      CCLR_C: h = ev[FLG_C];
      CCLR_D: h = ev[FLG_D];
      default: h = 1'b0;
    endcase
    return h;
  endfunction

  // Module stop gates counting and register access
  assign halted = halt_ctrl[HALT_BIT];
  assign acc_ok = !halted || (bus.addr == ADR_HALT);

  // Address decode of the register port
  always_comb
  begin
    cnt_wr = '0;
    flag_wr = '0;
    flag_rd = '0;
    ioc_wr = '0;
    mode_wr = '0;
    greg_wr = '0;
    for (int ch = 0; ch < NCH; ch++)
    begin
      cnt_wr[ch] = bus.wr && acc_ok && hit(bus.addr, ADR_CNT_BASE, ch);
      flag_wr[ch] = bus.wr && acc_ok && hit(bus.addr, ADR_FLAG_BASE, ch);
      flag_rd[ch] = bus.rd && acc_ok && hit(bus.addr, ADR_FLAG_BASE, ch);
      ioc_wr[ch] = bus.wr && acc_ok && hit(bus.addr, ADR_IOC_BASE, ch);
      mode_wr[ch] = bus.wr && acc_ok && hit(bus.addr, ADR_MODE_BASE, ch);
    end
    for (int i = 0; i < NREG; i++)
    begin
      greg_wr[i] = bus.wr && acc_ok && hit(bus.addr, ADR_GREG_BASE, i);
    end
  end

  // Per-channel count, match and capture events
  always_comb
  begin
    run = '0;
    down = '0;
    match = '0;
    cap = '0;
    ovf = '0;
    unf = '0;
    own_clr = '0;
    for (int ch = 0; ch < NCH; ch++)
    begin
      run[ch] = run_ctrl[ch] && count_tick[ch] && !halted;
      // Down counting only outside channels 0 and 3, in phase mode
      down[ch] = !has_cd(ch) && mode[ch][MODE_UPDN]
                 && mode[ch][MODE_DOWN];
      for (int r = 0; r < 4; r++)
      begin
        if (reg_ok(ch, r))
        begin
          // Compare register matches while the counter runs
          match[ch][r] = !ioc[ch][IOC_CAP_LSB + r] && run[ch]
                         && (cnt[ch] == greg[greg_idx(ch, r)]);
          // Capture register takes its strobe unless halted
          cap[ch][r] = ioc[ch][IOC_CAP_LSB + r] && capture_evt[ch][r]
                       && !halted;
        end
      end
      ovf[ch] = run[ch] && !down[ch] && (cnt[ch] == GREG_RST);
      unf[ch] = run[ch] && down[ch] && (cnt[ch] == CNT_RST);
      own_clr[ch] = clr_hit(mode[ch][MODE_CCLR_LSB +: 3],
                            match[ch] | cap[ch]);
    end
  end

  // Synchronous preset and clear across channels
  always_comb
  begin
    sync_preset = |(cnt_wr & sync_sel[NCH-1:0]);
    sync_clr = 1'b0;
    for (int ch = 0; ch < NCH; ch++)
    begin
      if (sync_sel[ch] && own_clr[ch])
      begin
        sync_clr = 1'b1;
      end
    end
    clr = '0;
    for (int ch = 0; ch < NCH; ch++)
    begin
      // Synchronised channel selecting sync clear follows the others
      clr[ch] = own_clr[ch] || (sync_sel[ch] && sync_clr
                && mode[ch][MODE_CCLR_LSB +: 3] == CCLR_SYNC);
    end
  end

  // Control registers: run, sync, halt, io control and mode
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      run_ctrl <= RUN_RST;
      sync_sel <= SYNC_RST;
      halt_ctrl <= HALT_RST;
      ioc <= '0;
      mode <= '0;
    end
    else if (hw_standby)
    begin
      run_ctrl <= RUN_RST;
      sync_sel <= SYNC_RST;
      halt_ctrl <= HALT_RST;
      ioc <= '0;
      mode <= '0;
    end
    else
    begin
      // Halt register stays reachable in module stop
      if (bus.wr && bus.addr == ADR_HALT)
      begin
        halt_ctrl <= bus.wdata;
      end
      // Reserved bits 7 and 6 always hold zero
      if (bus.wr && acc_ok && bus.addr == ADR_RUN)
      begin
        run_ctrl <= bus.wdata[7:0] & CHAN_MASK;
      end
      if (bus.wr && acc_ok && bus.addr == ADR_SYNC)
      begin
        sync_sel <= bus.wdata[7:0] & CHAN_MASK;
      end
      for (int ch = 0; ch < NCH; ch++)
      begin
        if (ioc_wr[ch])
        begin
          ioc[ch] <= bus.wdata[7:0];
        end
        if (mode_wr[ch])
        begin
          mode[ch] <= bus.wdata[7:0];
        end
      end
    end
  end

  // Counters: preset, clear, count
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt <= '0;
    end
    else if (hw_standby)
    begin
      cnt <= '0;
    end
    else
    begin
      for (int ch = 0; ch < NCH; ch++)
      begin
        if (cnt_wr[ch] || (sync_sel[ch] && sync_preset))
        begin
          cnt[ch] <= bus.wdata;
        end
        else if (clr[ch])
        begin
          cnt[ch] <= CNT_RST;
        end
        else if (run[ch] && down[ch])
        begin
          cnt[ch] <= cnt[ch] - ONE16;
        end
        else if (run[ch])
        begin
          cnt[ch] <= cnt[ch] + ONE16;
        end
      end
    end
  end

  // General registers: capture, buffer transfer, software write
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      greg <= {NREG{GREG_RST}};
    end
    else if (hw_standby)
    begin
      greg <= {NREG{GREG_RST}};
    end
    else
    begin
      for (int ch = 0; ch < NCH; ch++)
      begin
        for (int r = 0; r < 4; r++)
        begin
          if (reg_ok(ch, r) && cap[ch][r])
          begin
            greg[greg_idx(ch, r)] <= cnt[ch];
          end
        end
        if (has_cd(ch))
        begin
          // Buffer pairs: C with A, D with B
          for (int r = 0; r < 2; r++)
          begin
            if (mode[ch][MODE_BUFA + r] && match[ch][r])
            begin
              greg[greg_idx(ch, r)] <= greg[greg_idx(ch, r + 2)];
            end
            if (mode[ch][MODE_BUFA + r] && cap[ch][r])
            begin
              greg[greg_idx(ch, r + 2)] <= greg[greg_idx(ch, r)];
            end
          end
        end
      end
      // Software write wins over hardware in the same cycle
      for (int i = 0; i < NREG; i++)
      begin
        if (greg_wr[i])
        begin
          greg[i] <= bus.wdata;
        end
      end
    end
  end

  // Status flags and the read-as-one arming for clearing
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      flag <= '0;
      armed <= '0;
    end
    else if (hw_standby)
    begin
      flag <= '0;
      armed <= '0;
    end
    else
    begin
      for (int ch = 0; ch < NCH; ch++)
      begin
        for (int b = 0; b < NFLG; b++)
        begin
          logic ev; // Hardware set event
          logic ok; // Flag exists on this channel
          logic sw_clr; // Zero written after reading one
          logic tx_clr; // Cleared by transfer activation
          ev = 1'b0;
          ok = 1'b0;
          sw_clr = 1'b0;
          tx_clr = 1'b0;
          if (b < 4)
          begin
            ev = match[ch][b] || cap[ch][b];
            ok = reg_ok(ch, b);
            tx_clr = xfer.act[ch][b]
                     && !xfer.disable_after_transfer_bit[ch][b];
          end
          else if (b == FLG_V)
          begin
            ev = ovf[ch];
            ok = 1'b1;
          end
          else
          begin
            ev = unf[ch];
            ok = !has_cd(ch);
          end
          // Writing one leaves the flag alone
          sw_clr = flag_wr[ch] && !bus.wdata[b] && armed[ch][b];
          // Set beats a coincident clear
          flag[ch][b] <= ok && (ev || (flag[ch][b] && !sw_clr
                                       && !tx_clr));
          if (flag_rd[ch] && flag[ch][b])
          begin
            armed[ch][b] <= 1'b1;
          end
          else if (flag_wr[ch] || !flag[ch][b])
          begin
            armed[ch][b] <= 1'b0;
          end
        end
      end
    end
  end

  // Compare output pins
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_out <= '0;
      pin_oe <= '0;
    end
    else if (hw_standby)
    begin
      pin_out <= '0;
      pin_oe <= '0;
    end
    else
    begin
      for (int ch = 0; ch < NCH; ch++)
      begin
        if (ioc_wr[ch])
        begin
          pin_oe[ch] <= bus.wdata[IOC_OE];
        end
        if (ioc_wr[ch] && !run_ctrl[ch])
        begin
          pin_out[ch] <= bus.wdata[IOC_INIT];
        end
        else if (ioc[ch][IOC_OE] && match[ch][FLG_A])
        begin
          pin_out[ch] <= !pin_out[ch];
        end
      end
    end
  end

  // Read data, valid in the cycle after the read strobe
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_data <= '0;
    end
    else
    begin
      rd_data <= '0;
      if (bus.rd && acc_ok)
      begin
        if (bus.addr == ADR_HALT)
        begin
          rd_data <= halt_ctrl;
        end
        if (bus.addr == ADR_RUN)
        begin
          rd_data <= {8'h00, run_ctrl};
        end
        if (bus.addr == ADR_SYNC)
        begin
          rd_data <= {8'h00, sync_sel};
        end
        for (int ch = 0; ch < NCH; ch++)
        begin
          if (hit(bus.addr, ADR_FLAG_BASE, ch))
          begin
            // Direction reads one on up-only channels; bit 6 reads one
            rd_data <= {8'h00, has_cd(ch) || !down[ch], 1'b1, flag[ch]};
          end
          if (hit(bus.addr, ADR_CNT_BASE, ch))
          begin
            rd_data <= cnt[ch];
          end
          if (hit(bus.addr, ADR_IOC_BASE, ch))
          begin
            rd_data <= {8'h00, ioc[ch]};
          end
          if (hit(bus.addr, ADR_MODE_BASE, ch))
          begin
            rd_data <= {8'h00, mode[ch]};
          end
        end
        for (int i = 0; i < NREG; i++)
        begin
          if (hit(bus.addr, ADR_GREG_BASE, i))
          begin
            rd_data <= greg[i];
          end
        end
      end
    end
  end

endmodule

// ### mct_timer_sva.sv
`timescale 1ns/1ns
module mct_timer_chk (
  input wire logic clk_sys, // System clock
  input wire logic rst_b, // Reset, active low
  input wire logic hw_standby, // Hardware standby
  input wire mct_pkg::mct_bus_req_t bus, // Register port request
  input wire logic [15:0] rd_data, // Read data
  input wire logic [5:0] pin_out, // Compare output level
  input wire logic [5:0] pin_oe // Output drive enable
);
  import mct_pkg::*;
  logic [15:0] halt_q; // Shadow of the halt register
  logic [7:0] run_q; // Shadow of the run register
  logic [7:0] sync_q; // Shadow of the sync register
  logic halted; // Timer in module stop
  assign halted = halt_q[HALT_BIT];
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  // Halt shadow takes writes even while halted
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      halt_q <= HALT_RST;
    else if (hw_standby)
      halt_q <= HALT_RST;
    else if (bus.wr && bus.addr == ADR_HALT)
      halt_q <= bus.wdata;
  end
  // Run and sync shadows; reserved bits stay zero
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      run_q <= RUN_RST;
      sync_q <= SYNC_RST;
    end
    else if (hw_standby)
    begin
      run_q <= RUN_RST;
      sync_q <= SYNC_RST;
    end
    else if (bus.wr && !halted && bus.addr == ADR_RUN)
      run_q <= bus.wdata[7:0] & CHAN_MASK;
    else if (bus.wr && !halted && bus.addr == ADR_SYNC)
      sync_q <= bus.wdata[7:0] & CHAN_MASK;
  end
  // Accepted read of one address
  sequence rd_at(logic [7:0] a);
    bus.rd && bus.addr == a && !halted && !hw_standby;
  endsequence
  run_readback_a: assert property (
    rd_at(ADR_RUN) |=> rd_data == {8'h00, $past(run_q)})
    else $error("run register read back wrong");
  sync_readback_a: assert property (
    rd_at(ADR_SYNC) |=> rd_data == {8'h00, $past(sync_q)})
    else $error("sync register read back wrong");
  halt_readback_a: assert property (
    bus.rd && bus.addr == ADR_HALT && !hw_standby
      |=> rd_data == $past(halt_q))
    else $error("halt register read back wrong");
  halted_read_a: assert property (
    bus.rd && halted && bus.addr != ADR_HALT |=> rd_data == 16'h0000)
    else $error("register readable while halted");
  flag_fixed_a: assert property (
    rd_at(ADR_FLAG_BASE) |=> rd_data[15:6] == 10'h003)
    else $error("channel 0 direction or fixed bits wrong");
  for (genvar c = 0; c < NCH; c++)
  begin : g_pin
    logic io_wr; // Accepted write to this channel's io control
    assign io_wr = bus.wr && !halted && bus.addr == ADR_IOC_BASE + 8'(c);
    pin_hold_a: assert property (
      !run_q[c] && !io_wr && !hw_standby |=> $stable(pin_out[c]))
      else $error("pin level moved while stopped");
    oe_hold_a: assert property (
      !run_q[c] && !io_wr && !hw_standby |=> $stable(pin_oe[c]))
      else $error("pin enable moved while stopped");
    pin_init_a: assert property (
      !run_q[c] && io_wr && !hw_standby
        |=> pin_out[c] == $past(bus.wdata[IOC_INIT]))
      else $error("pin missed its initial level");
  end
endmodule

// ### mct_xfer_model.sv
`timescale 1ns/1ns
module mct_xfer_model (
  input wire logic clk_sys, // System clock
  output mct_pkg::mct_xfer_t xfer // Activations toward the timer
);
  import mct_pkg::*;
  // Idle until a transfer is commanded
  initial
  begin
    xfer = '0;
  end
  // One-cycle activation; the disable bit is scrambled once released
  task automatic activate(input int ch, input int r, input logic dis);
    mct_xfer_t v; // Pattern built whole, then driven in one go
    v = '0;
    v.act[ch][r] = 1'b1;
    v.disable_after_transfer_bit[ch][r] = dis;
    @(posedge clk_sys);
    xfer <= v;
    @(posedge clk_sys);
    v.act = '0;
    v.disable_after_transfer_bit[ch][r] = ~dis;
    xfer <= v;
  endtask
endmodule

// ### mct_timer_test.sv
`timescale 1ns/1ns
module mct_timer_test;
  import mct_pkg::*;
  logic clk_sys; // System clock
  logic rst_b; // Reset, active low
  logic hw_standby; // Hardware standby request
  mct_bus_req_t bus; // Register port request
  logic [15:0] rd_data; // Read data
  logic [5:0] count_tick; // Count enables
  logic [5:0][3:0] capture_evt; // Capture strobes
  mct_xfer_t xfer; // Transfer activations
  logic [5:0] pin_out; // Compare output level
  logic [5:0] pin_oe; // Output drive enable
  int error_cnt; // Mismatches seen
  int total_checks; // Comparisons made

  mct_timer mct_timer_i (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .hw_standby(hw_standby),
    .bus(bus),
    .rd_data(rd_data),
    .count_tick(count_tick),
    .capture_evt(capture_evt),
    .xfer(xfer),
    .pin_out(pin_out),
    .pin_oe(pin_oe)
  );
  mct_xfer_model mct_xfer_model_i (
    .clk_sys(clk_sys),
    .xfer(xfer)
  );

  // 100 ns clock
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Verdict and end of run
  task automatic test_done;
    if (error_cnt == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
    #1;
  endtask

  // One-cycle read, data taken in the following cycle
  task automatic rc(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    #1;
    chk(rd_data, exp);
  endtask

  // Count enables high for n edges
  task automatic tick(input logic [5:0] m, input int n);
    @(posedge clk_sys);
    count_tick <= m;
    repeat (n) @(posedge clk_sys);
    count_tick <= 6'h00;
    #1;
  endtask

  // Hang guard
  initial
  begin
    #3000000;
    error_cnt++;
    $display("CHECK FAILED %0t: run timed out", $time);
    test_done();
  end

  // Main sequence
  initial
  begin
    rst_b = 1'b0;
    hw_standby = 1'b0;
    bus = '0;
    count_tick = 6'h00;
    capture_evt = '0;
    error_cnt = 0;
    total_checks = 0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    rc(ADR_HALT, HALT_RST);
    wr(ADR_RUN, 16'h0001);
    rc(ADR_RUN, 16'h0000);
    wr(ADR_HALT, 16'h0000);
    rc(ADR_HALT, 16'h0000);
    rc(ADR_RUN, RUN_RST);
    for (int i = 0; i < NCH; i++)
    begin
      rc(ADR_FLAG_BASE + 8'(i), 16'h00c0);
      rc(ADR_CNT_BASE + 8'(i), CNT_RST);
    end
    for (int i = 0; i < NREG; i++)
    begin
      rc(ADR_GREG_BASE + 8'(i), GREG_RST);
    end
    wr(ADR_RUN, 16'h00ff);
    rc(ADR_RUN, 16'h003f);
    wr(ADR_SYNC, 16'h00ff);
    rc(ADR_SYNC, 16'h003f);
    wr(ADR_RUN, 16'h0000);
    wr(ADR_SYNC, 16'h0000);
    rc(8'hff, 16'h0000);
    // Compare match on channel 0, register A
    wr(ADR_GREG_BASE, 16'h0005);
    wr(ADR_IOC_BASE, 16'h0020);
    chk({10'h000, pin_oe}, 16'h0001);
    wr(ADR_RUN, 16'h0001);
    tick(6'h01, 3);
    rc(ADR_CNT_BASE, 16'h0003);
    tick(6'h01, 3);
    rc(ADR_CNT_BASE, 16'h0006);
    rc(ADR_FLAG_BASE, 16'h00c1);
    chk({10'h000, pin_out}, 16'h0001);
    wr(ADR_RUN, 16'h0000);
    tick(6'h01, 2);
    rc(ADR_CNT_BASE, 16'h0006);
    chk({10'h000, pin_out}, 16'h0001);
    wr(ADR_IOC_BASE, 16'h0020);
    chk({10'h000, pin_out}, 16'h0000);
    // Clearing only by zero after a read of one
    wr(ADR_FLAG_BASE, 16'h00ff);
    wr(ADR_FLAG_BASE, 16'h0000);
    rc(ADR_FLAG_BASE, 16'h00c1);
    wr(ADR_FLAG_BASE, 16'h0000);
    rc(ADR_FLAG_BASE, 16'h00c0);
    // Capture into register A; transfer with the disable bit set leaves the flag
    wr(ADR_IOC_BASE, 16'h0021);
    @(posedge clk_sys);
    capture_evt[0][0] <= 1'b1;
    @(posedge clk_sys);
    capture_evt <= '0;
    rc(ADR_GREG_BASE, 16'h0006);
    rc(ADR_FLAG_BASE, 16'h00c1);
    mct_xfer_model_i.activate(0, 0, 1'b1);
    rc(ADR_FLAG_BASE, 16'h00c1);
    // Capture lands in the same cycle as a clearing write
    @(posedge clk_sys);
    bus <= '{addr: ADR_FLAG_BASE, wdata: 16'h0000, wr: 1'b1, rd: 1'b0};
    capture_evt[0][0] <= 1'b1;
    @(posedge clk_sys);
    bus.wr <= 1'b0;
    capture_evt <= '0;
    rc(ADR_FLAG_BASE, 16'h00c1);
    mct_xfer_model_i.activate(0, 0, 1'b0);
    rc(ADR_FLAG_BASE, 16'h00c0);
    // Synchronous preset and count direction
    wr(ADR_SYNC, 16'h0003);
    wr(ADR_CNT_BASE, 16'h1234);
    rc(ADR_CNT_BASE + 8'h01, 16'h1234);
    rc(ADR_CNT_BASE + 8'h02, 16'h0000);
    wr(ADR_MODE_BASE, 16'h0018);
    wr(ADR_MODE_BASE + 8'h01, 16'h0018);
    wr(ADR_RUN, 16'h0003);
    tick(6'h03, 2);
    wr(ADR_RUN, 16'h0000);
    rc(ADR_CNT_BASE, 16'h1236);
    rc(ADR_CNT_BASE + 8'h01, 16'h1232);
    // Match A on channel 0 clears both synced counters; C reloads A
    wr(ADR_IOC_BASE, 16'h0000);
    wr(ADR_GREG_BASE, 16'h1238);
    wr(ADR_GREG_BASE + 8'h02, 16'h0040);
    wr(ADR_MODE_BASE, 16'h0021);
    wr(ADR_MODE_BASE + 8'h01, 16'h0003);
    wr(ADR_RUN, 16'h0003);
    tick(6'h03, 3);
    wr(ADR_RUN, 16'h0000);
    rc(ADR_CNT_BASE, 16'h0000);
    rc(ADR_CNT_BASE + 8'h01, 16'h0000);
    rc(ADR_GREG_BASE, 16'h0040);
    rc(ADR_FLAG_BASE, 16'h00c1);
    // Hardware standby restores everything
    @(posedge clk_sys);
    hw_standby <= 1'b1;
    @(posedge clk_sys);
    hw_standby <= 1'b0;
    rc(ADR_HALT, HALT_RST);
    wr(ADR_HALT, 16'h0000);
    rc(ADR_CNT_BASE, CNT_RST);
    rc(ADR_GREG_BASE, GREG_RST);
    rc(ADR_SYNC, SYNC_RST);
    chk({10'h000, pin_out}, 16'h0000);
    // Halt again while stopped; run write is blocked
    wr(ADR_HALT, 16'h2000);
    wr(ADR_RUN, 16'h0001);
    rc(ADR_GREG_BASE, 16'h0000);
    wr(ADR_HALT, 16'h0000);
    rc(ADR_RUN, RUN_RST);
    test_done();
  end
endmodule

bind mct_timer mct_timer_chk mct_timer_chk_i (
  .clk_sys(clk_sys),
  .rst_b(rst_b),
  .hw_standby(hw_standby),
  .bus(bus),
  .rd_data(rd_data),
  .pin_out(pin_out),
  .pin_oe(pin_oe)
);
